/* logic/csb_pkg.sv */
package csb_pkg;

  // ----------------------------------------------------------------
  // Clock and beeper timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ  = 250;
  localparam int unsigned BEEP_MS  = 400;
  localparam int unsigned GAP_MS   = 200;
  localparam int unsigned BEEP_CYC = BEEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned GAP_CYC  = GAP_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W    = 27;
  localparam int          NCH      = 4;
  localparam int          FAIL_W   = 6;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CAL  = 8'h00;
  localparam logic [7:0] A_BW   = 8'h04;
  localparam logic [7:0] A_BEEP = 8'h08;
  localparam logic [7:0] A_AUTO_SETUP_SHORT = 8'h0C;
  localparam logic [7:0] A_FCAL = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;

  // ----------------------------------------------------------------
  // Field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int P_LEAD = 4;
  localparam int P_SRCV = 6;
  localparam int P_BUSY = 8;
  localparam int P_DONE = 9;
  localparam int P_REFU = 1;
  localparam logic [1:0] BZ_BEEP = 2'h0;
  localparam logic [1:0] BZ_ON   = 2'h1;
  localparam logic [1:0] BZ_OFF  = 2'h2;
  localparam logic RST_CAL_EN = 1'b1;
  localparam logic RST_BW_EN  = 1'b0;
  localparam logic [5:0] FAIL_ALL  = 6'h3F;
  localparam logic [5:0] FAIL_2CH  = 6'h33;
  localparam logic [3:0] CH_ALL4   = 4'hF;
  localparam logic [3:0] CH_ALL2   = 4'h3;

  typedef enum logic [1:0] {BZ_IDLE, BZ_SND, BZ_GAP, BZ_CONT} csb_bz_t;

endpackage

/* logic/csb_seq_if.sv */
`timescale 1ns/1ps
interface csb_seq_if;
  logic       beep_req;
  logic       cont_on;
  logic       cont_off;
  logic       sounding;
  logic       auto_setup_short_go;
  logic [3:0] trace_on;
  logic [3:0] sig_seen;
  logic       four_ch;
  logic [3:0] auto_setup_short_traces;
  logic [1:0] auto_setup_short_lead;
  logic       auto_setup_short_lvld;
  logic       auto_setup_short_done;
  modport ctl (output beep_req, cont_on, cont_off, auto_setup_short_go, trace_on,
               sig_seen, four_ch, input sounding, auto_setup_short_traces,
               auto_setup_short_lead, auto_setup_short_lvld, auto_setup_short_done);
  modport bz  (input beep_req, cont_on, cont_off, output sounding);
  modport as  (input auto_setup_short_go, trace_on, sig_seen, four_ch,
               output auto_setup_short_traces, auto_setup_short_lead, auto_setup_short_lvld, auto_setup_short_done);
endinterface

/* logic/csb_beeper.sv */
`timescale 1ns/1ps
module csb_beeper import csb_pkg::*; #(
  parameter int          CW       = CNT_W,
  parameter int unsigned BEEP_LEN = BEEP_CYC,
  parameter int unsigned GAP_LEN  = GAP_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Beeper requests and state.
  csb_seq_if.bz    b
);

  typedef struct packed {
    csb_bz_t       st;
    logic [CW-1:0] cnt;
    logic          pend;
    logic          snd;
  } csb_bz_state_t;

  csb_bz_state_t r;
  csb_bz_state_t n;

  // A request during a beep or its gap is held, so two back-to-back
  // beeps always stay separated by the hold-off interval.
  always_comb begin
    n = r;
    case (r.st)
      BZ_IDLE: begin
        if (b.beep_req) begin
          n.st  = BZ_SND;
          n.cnt = '0;
        end
      end
      BZ_SND: begin
        if (b.beep_req) n.pend = 1'b1;
        if (r.cnt == CW'(BEEP_LEN - 1)) begin
          n.st  = BZ_GAP;
          n.cnt = '0;
        end else n.cnt = r.cnt + 1'b1;
      end
      BZ_GAP: begin
        if (r.cnt == CW'(GAP_LEN - 1)) begin
          n.st   = (r.pend || b.beep_req) ? BZ_SND : BZ_IDLE;
          n.pend = 1'b0;
          n.cnt  = '0;
        end else begin
          n.cnt = r.cnt + 1'b1;
          if (b.beep_req) n.pend = 1'b1;
        end
      end
      default: ;
    endcase
    if (b.cont_on) begin
      n.st   = BZ_CONT;
      n.pend = 1'b0;
    end else if (b.cont_off) begin
      n.st   = BZ_IDLE;
      n.pend = 1'b0;
    end
    n.snd = (n.st == BZ_SND) || (n.st == BZ_CONT);
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) r <= '0;
    else r <= n;
  end

  assign b.sounding = r.snd;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  beep_length_a: assert property (
    (r.st == BZ_SND && n.st == BZ_GAP) |-> r.cnt == CW'(BEEP_LEN - 1))
    else $error("beep ended at wrong length");
  gap_silent_a: assert property (
    (r.st == BZ_GAP) |-> (!b.sounding ##0 n.st != BZ_SND ||
                          r.cnt == CW'(GAP_LEN - 1) || b.cont_on))
    else $error("hold-off gap cut short");
  cont_on_a: assert property (
    b.cont_on |=> b.sounding ##1 (b.sounding || $past(b.cont_off)))
    else $error("continuous beeper did not sound");

endmodule

/* logic/csb_autoset.sv */
`timescale 1ns/1ps
module csb_autoset import csb_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Auto-setup request and selection.
  csb_seq_if.as    a
);

  typedef struct packed {
    logic [3:0] trc;
    logic [1:0] lead;
    logic       lvld;
    logic       done;
  } csb_as_state_t;

  csb_as_state_t r;
  csb_as_state_t n;
  logic [3:0]    full;
  logic [3:0]    sel;
  logic [3:0]    pick;
  logic          one;

  // Lowest-numbered hit wins, so the loop runs from the top down.
  always_comb begin
    n      = r;
    n.done = a.auto_setup_short_go;
    full   = a.four_ch ? CH_ALL4 : CH_ALL2;
    sel    = ((a.trace_on & full) != 4'h0) ? (a.trace_on & full)
                                           : full;
    one    = (sel & (sel - 4'h1)) == 4'h0;
    pick   = one ? sel : (sel & a.sig_seen);
    if (a.auto_setup_short_go) begin
      n.trc  = sel;
      n.lvld = pick != 4'h0;
      n.lead = 2'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
        if (pick[i]) n.lead = 2'(i);
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) r <= '0;
    else r <= n;
  end

  assign a.auto_setup_short_traces = r.trc;
  assign a.auto_setup_short_lead   = r.lead;
  assign a.auto_setup_short_lvld   = r.lvld;
  assign a.auto_setup_short_done   = r.done;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  none_on_a: assert property (
    (a.auto_setup_short_go && a.trace_on == 4'h0 && a.four_ch)
      |=> a.auto_setup_short_done && a.auto_setup_short_traces == 4'hF)
    else $error("no traces on but not all channels taken");
  lowest_a: assert property (
    (a.auto_setup_short_go && a.trace_on == 4'hF && a.four_ch &&
     a.sig_seen == 4'h6) |=> a.auto_setup_short_lead == 2'h1 && a.auto_setup_short_lvld)
    else $error("lead channel is not the lowest with signal");
  single_ch_a: assert property (
    (a.auto_setup_short_go && a.trace_on == 4'h4 && a.four_ch)
      |=> a.auto_setup_short_lead == 2'h2 && a.auto_setup_short_lvld && a.auto_setup_short_traces == 4'h4)
    else $error("single channel not chosen for time base");

endmodule

/* logic/csb_ctrl.sv */
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Periodic calibration enabled after power-up.
// - Calibration enable set ON or OFF.
// - Returning to local resumes periodic calibration; during a full calibration, its end restores the saved enable.
// - Query returns calibration enable state.
// - Auto-setup uses only channels with traces on.
// - No traces on: use and show all.
// - Lowest channel with signal picks sources.
// - Single enabled channel sets the time base.
// - Bandwidth filter flag set, cleared, queried.
// - Beep request sounds about 400 ms.
// - Back-to-back beep held off 200 ms.
// - Beeper ON sounds until OFF.
// - Beeper accepted in local and remote.
// - Full calibration runs the power-up sequence.
// - Restore prior state after full calibration.
// - Full calibration accepted only in remote.
// - Result only after calibration has ended.
// - Failure bitmask: channels, converter, trigger.
// - Zero result means no failure found.
// - Settings need remote; queries work anywhere.
module csb_ctrl import csb_pkg::*; #(
  parameter int unsigned BEEP_CYCLES = BEEP_CYC,
  parameter int unsigned GAP_CYCLES  = GAP_CYC
) (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Operating state and configuration.
  input  wire logic        remote_i,
  input  wire logic        four_ch_i,
  // Front end status.
  input  wire logic [3:0]  trace_on_i,
  input  wire logic [3:0]  sig_seen_i,
  input  wire logic        cal_done_i,
  input  wire logic [5:0]  cal_fail_i,
  // Front end control.
  output logic             periodic_cal_o,
  output logic             cal_start_o,
  output logic             bw_filter_o,
  output logic             beeper_o,
  output logic      [3:0]  trace_on_o,
  output logic      [1:0]  tb_src_o,
  output logic      [1:0]  trig_src_o,
  output logic             src_valid_o,
  output logic             auto_setup_short_done_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rs1;
    logic        rs2;
    logic        rs3;
    logic        remote;
    logic        four;
    logic        cal_en;
    logic        saved;
    logic        bw_en;
    logic        busy;
    logic        done;
    logic [5:0]  fail;
    logic        cstart;
    logic        wpend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
    logic        rdy;
    logic        refused;
    logic        beep;
    logic        on;
    logic        off;
    logic        go;
    logic        snd;
    logic [3:0]  trc;
    logic [1:0]  tb;
    logic        srcv;
    logic        asdone;
    logic        pcal;
  } csb_main_t;

  csb_main_t   r;
  csb_main_t   n;
  logic        aphase;
  logic [31:0] rd;
  logic [5:0]  fmask;

  csb_seq_if sq ();

  // ----------------------------------------------------------------
  // Helper blocks
  // ----------------------------------------------------------------
  csb_beeper #(
    .CW       (CNT_W),
    .BEEP_LEN (BEEP_CYCLES),
    .GAP_LEN  (GAP_CYCLES)
  ) u_beeper (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .b     (sq)
  );

  csb_autoset u_autoset (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .a     (sq)
  );

  // Requests go out as one-cycle pulses straight from the state.
  assign sq.beep_req = r.beep;
  assign sq.cont_on  = r.on;
  assign sq.cont_off = r.off;
  assign sq.auto_setup_short_go  = r.go;
  assign sq.trace_on = trace_on_i;
  assign sq.sig_seen = sig_seen_i;
  assign sq.four_ch  = r.four;

  // A transfer is taken only when the bus is ready and it is real.
  assign aphase = hsel_i && hready_i && htrans_i[1];

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // The mask hides channel 3/4 failures on a two-channel build, even
  // if the front end reports noise on those unused inputs.
  always_comb begin
    rd    = 32'h0000_0000;
    fmask = r.four ? FAIL_ALL : FAIL_2CH;
    if (haddr_i[7:0] == A_CAL) begin
      rd[0] = r.cal_en;
    end else if (haddr_i[7:0] == A_BW) begin
      rd[0] = r.bw_en;
    end else if (haddr_i[7:0] == A_BEEP) begin
      rd[0] = r.snd;
    end else if (haddr_i[7:0] == A_AUTO_SETUP_SHORT) begin
      rd[3:0]                = r.trc;
      rd[P_LEAD +: 2]        = r.tb;
      rd[P_SRCV]             = r.srcv;
    end else if (haddr_i[7:0] == A_FCAL) begin
      // Zero with done set means a clean calibration.
      rd[FAIL_W-1:0] = r.done ? (r.fail & fmask) : 6'h00;
      rd[P_BUSY]     = r.busy;
      rd[P_DONE]     = r.done;
    end else if (haddr_i[7:0] == A_STAT) begin
      rd[0]      = r.remote;
      rd[P_REFU] = r.refused;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = r;
    n.beep   = 1'b0;
    n.on     = 1'b0;
    n.off    = 1'b0;
    n.go     = 1'b0;
    n.cstart = 1'b0;
    n.rdy    = 1'b1;
    n.four   = four_ch_i;

    // Remote line: a change is believed once two stages agree.
    n.rs1 = remote_i;
    n.rs2 = r.rs1;
    n.rs3 = r.rs2;
    if (r.rs2 == r.rs3) n.remote = r.rs3;

    // Address phase.
    n.wpend = aphase && hwrite_i;
    if (aphase) n.waddr = haddr_i[7:0];
    if (aphase && !hwrite_i) n.rdata = rd;

    // Data phase of a write. The beeper is the one setting that is
    // taken in local as well; any other local setting is dropped.
    if (r.wpend) begin
      if (r.waddr == A_BEEP) begin
        n.beep = hwdata_i[1:0] == BZ_BEEP;
        n.on   = hwdata_i[1:0] == BZ_ON;
        n.off  = hwdata_i[1:0] == BZ_OFF;
      end else if (!r.remote) begin
        n.refused = 1'b1;
      end else begin
        n.refused = 1'b0;
        if (r.waddr == A_CAL) begin
          n.cal_en = hwdata_i[0];
        end else if (r.waddr == A_BW) begin
          n.bw_en = hwdata_i[0];
        end else if (r.waddr == A_AUTO_SETUP_SHORT) begin
          n.go = hwdata_i[0];
        end else if (r.waddr == A_FCAL && hwdata_i[0] && !r.busy) begin
          n.busy   = 1'b1;
          n.done   = 1'b0;
          n.saved  = r.cal_en;
          n.cstart = 1'b1;
        end
      end
    end

    // Calibration end: capture the outcome and put back the enable
    // that stood when the full calibration was started. A calibration enable written meanwhile is
    // lost, which keeps the restore simple and predictable.
    if (r.busy && !r.cstart && cal_done_i) begin
      n.busy   = 1'b0;
      n.done   = 1'b1;
      n.fail   = cal_fail_i;
      n.cal_en = r.saved;
    end

    // Leaving remote sets the calibration enable; a full calibration still running later puts back its saved enable.
    if (r.remote && !n.remote) n.cal_en = 1'b1;

    // Periodic calibration stands still during a full calibration.
    n.pcal = n.cal_en && !n.busy;

    // Auto-setup outcome and beeper level.
    n.asdone = sq.auto_setup_short_done;
    if (sq.auto_setup_short_done) begin
      n.trc  = sq.auto_setup_short_traces;
      n.tb   = sq.auto_setup_short_lead;
      n.srcv = sq.auto_setup_short_lvld;
    end
    n.snd = sq.sounding;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r        <= '0;
      r.cal_en <= RST_CAL_EN;
      r.pcal   <= RST_CAL_EN;
      r.bw_en  <= RST_BW_EN;
      r.rdy    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata_o       = r.rdata;
  assign hreadyout_o    = r.rdy;
  assign hresp_o        = !r.rdy;
  assign periodic_cal_o = r.pcal;
  assign cal_start_o    = r.cstart;
  assign bw_filter_o    = r.bw_en;
  assign beeper_o       = r.snd;
  assign trace_on_o     = r.trc;
  assign tb_src_o       = r.tb;
  assign trig_src_o     = r.tb;
  assign src_valid_o    = r.srcv;
  assign auto_setup_short_done_o    = r.asdone;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_cal_end;
    r.busy && !r.cstart && cal_done_i;
  endsequence

  sequence s_local_wr;
    r.wpend && !r.remote && r.waddr != A_BEEP;
  endsequence

  cal_reset_a: assert property (
    $past(rst_i) |-> r.cal_en && periodic_cal_o)
    else $error("periodic calibration off after reset");
  cal_off_a: assert property (
    (r.wpend && r.waddr == A_CAL && r.remote && !r.busy &&
     !hwdata_i[0] && n.remote) |=> !r.cal_en ##1 !periodic_cal_o)
    else $error("calibration OFF not taken");
  local_resume_a: assert property (
    (r.remote && !n.remote) |=> r.cal_en)
    else $error("periodic calibration not resumed in local");
  cal_query_a: assert property (
    (aphase && !hwrite_i && haddr_i[7:0] == A_CAL)
      |=> hrdata_o[0] == $past(r.cal_en))
    else $error("calibration query wrong");
  bw_write_a: assert property (
    (r.wpend && r.waddr == A_BW && r.remote)
      |=> bw_filter_o == $past(hwdata_i[0]))
    else $error("bandwidth flag not updated");
  beep_local_a: assert property (
    (r.wpend && r.waddr == A_BEEP && !r.remote &&
     hwdata_i[1:0] == BZ_BEEP)
      |=> sq.beep_req ##1 (!sq.beep_req || $past(r.wpend)))
    else $error("beep refused in local");
  local_set_a: assert property (
    s_local_wr |=> $stable(r.bw_en) && !sq.auto_setup_short_go && r.refused)
    else $error("setting executed in local");
  fcal_local_a: assert property (
    (s_local_wr and (r.waddr == A_FCAL && !r.busy))
      |=> !cal_start_o && !r.busy)
    else $error("full calibration started in local");
  cal_pause_a: assert property (
    r.busy |-> !periodic_cal_o)
    else $error("periodic calibration during full calibration");
  cal_restore_a: assert property (
    s_cal_end |=> r.done && !r.busy && r.cal_en == $past(r.saved)
                  ##1 periodic_cal_o == $past(r.saved, 2))
    else $error("state not restored after calibration");
  fail_mask_a: assert property (
    (aphase && !hwrite_i && haddr_i[7:0] == A_FCAL && !r.four)
      |=> hrdata_o[3:2] == 2'h0)
    else $error("channel 3/4 failure on two-channel unit");

endmodule

/* verif/csb_host.sv */
`timescale 1ns/1ps
module csb_host (
  // Clock and bus answer.
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // Bus request and operating state.
  output logic             hsel_o,
  output logic      [31:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [2:0]  hsize_o,
  output logic      [31:0] hwdata_o,
  output logic             remote_o
);
  // ------------------------------------------------------------
  // Host side of the register bus
  // ------------------------------------------------------------

  // The host starts idle and in the local state.
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
    remote_o = 1'b0;
  end

  // One single word transfer; each phase holds until hready is seen high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h000000, a};
    htrans_o <= 2'h2;
    hwrite_o <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hwdata_o <= ~d; // Stale write data is never left on the bus.
  endtask

  // The state pin is synchronised inside, so allow it time to land.
  task automatic set_remote(input logic v);
    @(posedge clk_i);
    remote_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import csb_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hsel, hwrite, hready, hresp, remote;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans, tb_src, trig_src;
  logic [2:0]  hsize;
  logic        four_ch;
  logic        cal_done;
  logic [5:0]  cal_fail;
  logic [3:0]  trace_in;
  logic [3:0]  sig_in;
  logic [3:0]  trace_out;
  logic        pcal, cal_start, bw, beep, src_v, auto_setup_short_done;
  logic        prev = 1'b0;
  int          n_errors = 0;
  int          n_tests = 0;
  int          run = 0;
  int          last_hi = 0;
  int          last_lo = 0;

  csb_ctrl #(.BEEP_CYCLES(20), .GAP_CYCLES(10)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .remote_i(remote),
    .four_ch_i(four_ch), .trace_on_i(trace_in), .sig_seen_i(sig_in),
    .cal_done_i(cal_done), .cal_fail_i(cal_fail),
    .periodic_cal_o(pcal), .cal_start_o(cal_start), .bw_filter_o(bw),
    .beeper_o(beep), .trace_on_o(trace_out), .tb_src_o(tb_src),
    .trig_src_o(trig_src), .src_valid_o(src_v),
    .auto_setup_short_done_o(auto_setup_short_done));

  csb_host host (
    .clk_i(mclk_i), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
    .remote_o(remote));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Run lengths of the beeper drive, so pulse and gap widths can be judged.
  always @(posedge mclk_i) begin
    if (beep === prev) begin
      run++;
    end else begin
      if (prev === 1'b1) last_hi = run;
      else last_lo = run;
      run = 1;
    end
    prev = beep;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdat);
  endtask

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rdat);
  endtask

  // Bounded wait for a given beeper level.
  task automatic wait_beep(input logic v);
    int n;
    for (n = 0; n < 100 && beep !== v; n++) @(posedge mclk_i);
    chk({31'h0, beep}, {31'h0, v});
    @(posedge mclk_i);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------

  task automatic test_reset();
    rd(A_CAL);
    chk(rdat, 32'h1);
    chk({31'h0, pcal}, 32'h1);
    rd(A_BW);
    chk(rdat, 32'h0);
    rd(8'h20);
    chk(rdat, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test_reset done");
  endtask

  // Settings written in local are ignored and flagged.
  task automatic test_local();
    wr(A_CAL, 32'h0);
    rd(A_CAL);
    chk(rdat, 32'h1);
    rd(A_STAT);
    chk(rdat, 32'h2);
    $display("test_local done");
  endtask

  task automatic test_settings();
    host.set_remote(1'b1);
    wr(A_CAL, 32'h0);
    repeat (3) @(posedge mclk_i);
    chk({31'h0, pcal}, 32'h0);
    rd(A_CAL);
    chk(rdat, 32'h0);
    wr(A_BW, 32'h1);
    rd(A_BW);
    chk(rdat, 32'h1);
    chk({31'h0, bw}, 32'h1);
    wr(A_BW, 32'h0);
    repeat (3) @(posedge mclk_i);
    chk({31'h0, bw}, 32'h0);
    host.set_remote(1'b0);
    rd(A_CAL);
    chk(rdat, 32'h1);
    chk({31'h0, pcal}, 32'h1);
    $display("test_settings done");
  endtask

  // One auto-setup run; lead is only judged when it is expected valid.
  task automatic auto_setup_short(input logic [3:0] tr, input logic [3:0] sg,
                      input logic [3:0] et, input logic [1:0] el,
                      input logic ev);
    int n;
    trace_in <= tr;
    sig_in   <= sg;
    wr(A_AUTO_SETUP_SHORT, 32'h1);
    for (n = 0; n < 20 && auto_setup_short_done !== 1'b1; n++) @(posedge mclk_i);
    chk({31'h0, auto_setup_short_done}, 32'h1);
    chk({28'h0, trace_out}, {28'h0, et});
    chk({31'h0, src_v}, {31'h0, ev});
    if (ev) chk({28'h0, tb_src, trig_src}, {28'h0, el, el});
  endtask

  task automatic test_auto_setup_short();
    host.set_remote(1'b1);
    auto_setup_short(4'h0, 4'h8, 4'hF, 2'h3, 1'b1);
    auto_setup_short(4'hE, 4'hC, 4'hE, 2'h2, 1'b1);
    auto_setup_short(4'h4, 4'h0, 4'h4, 2'h2, 1'b1);
    auto_setup_short(4'h3, 4'h0, 4'h3, 2'h0, 1'b0);
    $display("test_auto_setup_short done");
  endtask

  // Full calibration with a chosen failure answer from the front end.
  task automatic fcal(input logic f4, input logic [5:0] fl,
                      input logic [5:0] ex);
    int n;
    four_ch <= f4;
    wr(A_FCAL, 32'h1);
    for (n = 0; n < 10 && cal_start !== 1'b1; n++) @(posedge mclk_i);
    chk({31'h0, cal_start}, 32'h1);
    chk({31'h0, pcal}, 32'h0);
    rd(A_FCAL);
    chk({22'h0, rdat[9:0]}, 32'h100);
    cal_done <= 1'b1;
    cal_fail <= fl;
    @(posedge mclk_i);
    cal_done <= 1'b0;
    cal_fail <= ~fl;
    repeat (4) @(posedge mclk_i);
    rd(A_FCAL);
    chk({22'h0, rdat[9:0]}, {22'h0, 4'h8, ex});
    chk({31'h0, pcal}, 32'h1);
  endtask

  task automatic test_fcal();
    int n;
    fcal(1'b1, 6'h15, 6'h15);
    fcal(1'b0, 6'h3F, 6'h33);
    fcal(1'b1, 6'h00, 6'h00);
    host.set_remote(1'b0);
    wr(A_FCAL, 32'h1);
    for (n = 0; n < 10 && cal_start !== 1'b1; n++) @(posedge mclk_i);
    chk({31'h0, cal_start}, 32'h0);
    $display("test_fcal done");
  endtask

  // Beeper is driven from the local state throughout.
  task automatic test_beep();
    wr(A_BEEP, {30'h0, BZ_BEEP});
    wait_beep(1'b1);
    wr(A_BEEP, {30'h0, BZ_BEEP});
    wait_beep(1'b0);
    chk(last_hi, 20);
    wait_beep(1'b1);
    chk(last_lo, 10);
    wait_beep(1'b0);
    chk(last_hi, 20);
    wr(A_BEEP, {30'h0, BZ_ON});
    repeat (40) @(posedge mclk_i);
    chk({31'h0, beep}, 32'h1);
    rd(A_BEEP);
    chk(rdat, 32'h1);
    wr(A_BEEP, {30'h0, BZ_OFF});
    repeat (3) @(posedge mclk_i);
    chk({31'h0, beep}, 32'h0);
    $display("test_beep done");
  endtask

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  initial begin
    four_ch  <= 1'b1;
    cal_done <= 1'b0;
    cal_fail <= 6'h00;
    trace_in <= 4'h0;
    sig_in   <= 4'h0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    test_reset();
    test_local();
    test_beep();
    test_settings();
    test_auto_setup_short();
    test_fcal();
    complete_run();
  end

  // The run needs a few hundred cycles; this limit only cuts hangs.
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule
